// >>> core/charge_setpoint_regs.sv
// Purpose: charge current and charge voltage set-point registers
// Assumes: host on the two-wire serial pins, word writes low byte first
// Notes:   no clock stretching; serial pins filtered through pin_sync
// Overview of operation
// RULE1: upper current bits weigh 4096 to 256 mA
// RULE2: lower current bits 7,6 weigh 128, 64 mA
// RULE3: current upper bits 7-5 set means invalid write
// RULE4: current lower bits 5-0 ignored
// RULE5: current register resets to zero
// RULE6: 2-4 cell linear pre-charge clamps to 384 mA
// RULE7: one cell pre-charge ends at 3 V, 384 mA
// RULE8: one cell 3-3.6 V stays linear, 2 A clamp
// RULE9: host writes voltage as one 16-bit word
// RULE10: voltage spans 1.024 to 19.2 V, 8 mV
// RULE11: out-of-range voltage write is discarded
// RULE12: voltage default follows strapped cell count
// RULE13: charging starts on current write with power good
// RULE14: host writes voltage before current if needed
// RULE15: zero voltage write keeps voltage, clears current
// RULE16: voltage code bits packed 16384 to 8 mV
// RULE17: current cleared on removal, reset, watchdog
// RULE18: 5 milliohm sense doubles current step
// RULE19: reads return last accepted values
module charge_setpoint_regs
  import charge_setpoint_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // two-wire serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // asynchronous status pins
  input  wire logic        input_power_good,
  input  wire logic        input_present_flag,
  input  wire logic        battery_present,
  input  wire logic [1:0]  cell_count_strap,
  input  wire logic        sense_5mohm,
  // on-chip controls and measurements
  input  wire logic        linear_precharge_enable,
  input  wire logic        reg_reset_cmd,
  input  wire logic        watchdog_event,
  input  wire logic [15:0] vbat_mv,
  input  wire logic [15:0] vsys_min_mv,
  // set points and charge control
  output logic      [15:0] charge_current_setpoint,
  output logic      [15:0] charge_voltage_setpoint,
  output logic      [15:0] current_limit_ma,
  output logic             charge_enable,
  output logic             precharge,
  output logic             battery_switch,
  output logic             regulate_at_vsys_min
);
  // ====================================================================
  // pin synchronisers
  logic [7:0] pins;
  logic       scl_s;
  logic       sda_s;
  logic       pgood_s;
  logic       present_s;
  logic       batt_s;
  logic [1:0] strap_s;
  logic       sense5_s;

  pin_sync #(.W(8)) u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in ({scl_in, sda_in, input_power_good, input_present_flag,
              battery_present, cell_count_strap, sense_5mohm}),
    .level  (pins)
  );
  assign {scl_s, sda_s, pgood_s, present_s, batt_s, strap_s, sense5_s}
    = pins;

  // ====================================================================
  // serial slave
  ser_state_t  state;
  ser_state_t  next_state;
  logic        scl_q;
  logic        sda_q;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        got_ptr;
  logic        next_got_ptr;
  logic        rw;
  logic        next_rw;
  logic        next_sda_oe;
  logic [7:0]  lo_hold;
  logic [7:0]  next_lo_hold;
  logic [7:0]  lo_ofs;
  logic [7:0]  next_lo_ofs;
  logic        host_ack;
  logic        next_host_ack;
  logic        wr_cur;
  logic        next_wr_cur;
  logic        wr_vol;
  logic        next_wr_vol;
  logic [15:0] wr_word;
  logic [15:0] next_wr_word;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  rd_byte;

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // read mux: last accepted values only
  always_comb begin
    case (ptr)
      CUR_LO_OFS: rd_byte = charge_current_setpoint[7:0];  // RULE19
      CUR_HI_OFS: rd_byte = charge_current_setpoint[15:8];
      VOL_LO_OFS: rd_byte = charge_voltage_setpoint[7:0];
      VOL_HI_OFS: rd_byte = charge_voltage_setpoint[15:8];
      default:    rd_byte = 8'h00;
    endcase
  end

  // protocol next state; a word commits only after its high byte
  always_comb begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_shift    = shift;
    next_ptr      = ptr;
    next_got_ptr  = got_ptr;
    next_rw       = rw;
    next_sda_oe   = sda_oe;
    next_lo_hold  = lo_hold;
    next_lo_ofs   = lo_ofs;
    next_host_ack = host_ack;
    next_wr_cur   = 1'b0;
    next_wr_vol   = 1'b0;
    next_wr_word  = wr_word;
    if (start_c) begin
      next_state   = SER_ADDR;
      next_bit_cnt = 4'h0;
      next_got_ptr = 1'b0;
      next_lo_ofs  = 8'h00;
      next_sda_oe  = 1'b0;
    end else if (stop_c) begin
      next_state  = SER_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        SER_IDLE: begin
          next_sda_oe = 1'b0;
        end
        SER_ADDR, SER_RXB: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (state == SER_ADDR) begin
              if (shift[7:1] == DEV_ADDR) begin
                next_sda_oe = 1'b1;
                next_rw     = shift[0];
                next_state  = SER_AACK;
              end else begin
                next_state = SER_IDLE;
              end
            end else begin
              next_sda_oe = 1'b1;
              next_state  = SER_RACK;
              if (!got_ptr) begin
                next_got_ptr = 1'b1;
                next_ptr     = shift;
              end else begin
                next_ptr = ptr + 8'h01;
                if (ptr == CUR_LO_OFS || ptr == VOL_LO_OFS) begin
                  next_lo_hold = shift;
                  next_lo_ofs  = ptr;
                end else if (ptr == CUR_HI_OFS && lo_ofs == CUR_LO_OFS) begin
                  next_wr_cur  = 1'b1;
                  next_wr_word = {shift, lo_hold};
                end else if (ptr == VOL_HI_OFS && lo_ofs == VOL_LO_OFS) begin
                  next_wr_vol  = 1'b1; // RULE9
                  next_wr_word = {shift, lo_hold};
                end
              end
            end
          end
        end
        SER_AACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (rw) begin
              next_shift  = rd_byte;
              next_sda_oe = ~rd_byte[7];
              next_state  = SER_TXB;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = SER_RXB;
            end
          end
        end
        SER_RACK: begin
          if (scl_fall) begin
            next_sda_oe  = 1'b0;
            next_bit_cnt = 4'h0;
            next_state   = SER_RXB;
          end
        end
        SER_TXB: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BYTE_BITS) begin
              next_sda_oe = 1'b0;
              next_state  = SER_TACK;
            end else begin
              next_shift  = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
            end
          end
        end
        SER_TACK: begin
          if (scl_rise) begin
            next_host_ack = ~sda_s;
            next_ptr      = ptr + 8'h01;
          end else if (scl_fall) begin
            if (host_ack) begin
              next_shift   = rd_byte;
              next_sda_oe  = ~rd_byte[7];
              next_bit_cnt = 4'h0;
              next_state   = SER_TXB;
            end else begin
              next_state = SER_IDLE;
            end
          end
        end
        default: begin
          next_state  = SER_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // serial registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state    <= SER_IDLE;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      ptr      <= 8'h00;
      got_ptr  <= 1'b0;
      rw       <= 1'b0;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
      lo_hold  <= 8'h00;
      lo_ofs   <= 8'h00;
      host_ack <= 1'b0;
      wr_cur   <= 1'b0;
      wr_vol   <= 1'b0;
      wr_word  <= 16'h0000;
    end else begin
      state    <= next_state;
      scl_q    <= scl_s;
      sda_q    <= sda_s;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
      ptr      <= next_ptr;
      got_ptr  <= next_got_ptr;
      rw       <= next_rw;
      sda_oe   <= next_sda_oe;
      sda_out  <= 1'b0; // open drain: only ever pulls low
      lo_hold  <= next_lo_hold;
      lo_ofs   <= next_lo_ofs;
      host_ack <= next_host_ack;
      wr_cur   <= next_wr_cur;
      wr_vol   <= next_wr_vol;
      wr_word  <= next_wr_word;
    end
  end

  // ====================================================================
  // set-point registers and charge control
  logic [2:0]  settle;
  logic [2:0]  next_settle;
  logic        batt_q;
  logic [15:0] next_cur;
  logic [15:0] next_vol;
  logic [15:0] next_limit;
  logic        next_chg_en;
  logic        next_pre;
  logic        next_bsw;
  logic        next_vsys_reg;
  logic [15:0] vol_def;
  logic [15:0] cur_ma;
  logic [15:0] vol_mv;
  logic        clear_cur;

  // strap decoding to default voltage
  always_comb begin
    case (strap_s)
      2'h0:    vol_def = VOL_DEF_1S; // RULE12
      2'h1:    vol_def = VOL_DEF_2S;
      2'h2:    vol_def = VOL_DEF_3S;
      default: vol_def = VOL_DEF_4S;
    endcase
  end

  // code bits sit where their weight is: masked word is mA or mV
  assign vol_mv = wr_word & VOL_KEEP_MASK; // RULE16 RULE10
  assign cur_ma = sense5_s ?
    {charge_current_setpoint[14:0], 1'b0} :           // RULE18
    charge_current_setpoint;                           // RULE1 RULE2
  // clears win over a write in the same cycle
  assign clear_cur = reg_reset_cmd | watchdog_event | ~present_s |
                     (batt_q & ~batt_s);               // RULE17

  always_comb begin
    next_settle   = settle;
    next_cur      = charge_current_setpoint;
    next_vol      = charge_voltage_setpoint;
    next_pre      = 1'b0;
    next_bsw      = 1'b0;
    next_vsys_reg = 1'b0;
    next_limit    = cur_ma;
    // default reloaded each cycle until the strap has passed the filter
    if (settle != STRAP_SETTLE) begin
      next_settle = settle + 3'h1;
      next_vol    = vol_def;                           // RULE12
    end
    if (wr_cur && (wr_word & CUR_RSVD_MASK) == CUR_RESET) begin
      next_cur = wr_word & CUR_KEEP_MASK;              // RULE3 RULE4
    end
    if (wr_vol && (wr_word & VOL_RSVD_MASK) == 16'h0000) begin
      if (vol_mv == 16'h0000) begin
        next_cur = CUR_RESET;                          // RULE15
      end else if (vol_mv >= VOL_MIN_MV && vol_mv <= VOL_MAX_MV) begin
        next_vol = vol_mv;                             // RULE11
      end
    end
    if (reg_reset_cmd) begin
      next_vol = vol_def;
    end
    if (clear_cur) begin
      next_cur = CUR_RESET;                            // RULE17
    end
    // pre-charge and linear switch behaviour
    if (strap_s == STRAP_ONE_CELL) begin
      next_pre = vbat_mv < ONE_CELL_PRE_MV;            // RULE7
    end else begin
      next_pre = vbat_mv < vsys_min_mv;                // RULE6
    end
    if (linear_precharge_enable && vbat_mv < vsys_min_mv) begin
      next_bsw      = 1'b1;                            // RULE8
      next_vsys_reg = 1'b1;                            // RULE6
      if (next_pre) begin
        if (cur_ma > PRECHG_CLAMP_MA) begin
          next_limit = PRECHG_CLAMP_MA;                // RULE6 RULE7
        end
      end else if (cur_ma > LIN_FAST_CLAMP_MA) begin
        next_limit = LIN_FAST_CLAMP_MA;                // RULE8
      end
    end
    // non-zero current with power good starts the charge
    next_chg_en = pgood_s && (next_cur != CUR_RESET);  // RULE13
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      settle                  <= 3'h0;
      batt_q                  <= 1'b0;
      charge_current_setpoint <= CUR_RESET;            // RULE5
      charge_voltage_setpoint <= VOL_DEF_1S;
      current_limit_ma        <= CUR_RESET;
      charge_enable           <= 1'b0;
      precharge               <= 1'b0;
      battery_switch          <= 1'b0;
      regulate_at_vsys_min    <= 1'b0;
    end else begin
      settle                  <= next_settle;
      batt_q                  <= batt_s;
      charge_current_setpoint <= next_cur;
      charge_voltage_setpoint <= next_vol;
      current_limit_ma        <= next_limit;
      charge_enable           <= next_chg_en;
      precharge               <= next_pre;
      battery_switch          <= next_bsw;
      regulate_at_vsys_min    <= next_vsys_reg;
    end
  end
endmodule : charge_setpoint_regs

// >>> core/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pins
// Assumes: inputs are asynchronous to mclk
// Notes:   output changes only when stages two and three agree
// ======================================================================
// synchroniser
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // one filter per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic next_level;
    always_comb begin
      next_level = level[i];
      if (stage2[i] == stage3[i]) begin
        next_level = stage3[i];
      end
    end
    always_ff @(posedge mclk) begin
      stage1[i] <= pin_in[i]; // only stage2 reads this flop
      stage2[i] <= stage1[i];
      stage3[i] <= stage2[i];
      if (rst) begin
        level[i] <= 1'b0;
      end else begin
        level[i] <= next_level;
      end
    end
  end
endmodule : pin_sync

// >>> inc/charge_setpoint_pkg.sv
// Purpose: shared constants for the charge set-point register bank
// Assumes: register values carry mA or mV directly once masked
// Notes:   serial slave address value is arbitrary
// ======================================================================
// package
package charge_setpoint_pkg;
  // serial slave address, value arbitrary
  localparam logic [6:0]  DEV_ADDR          = 7'h2A;
  localparam logic [3:0]  BYTE_BITS         = 4'h8;
  // register byte offsets
  localparam logic [7:0]  CUR_LO_OFS        = 8'h02;
  localparam logic [7:0]  CUR_HI_OFS        = 8'h03;
  localparam logic [7:0]  VOL_LO_OFS        = 8'h04;
  localparam logic [7:0]  VOL_HI_OFS        = 8'h05;
  // field layout
  localparam logic [15:0] CUR_RESET         = 16'h0000;
  localparam logic [15:0] CUR_RSVD_MASK     = 16'hE000;
  localparam logic [15:0] CUR_KEEP_MASK     = 16'h1FC0;
  localparam logic [15:0] VOL_RSVD_MASK     = 16'h8000;
  localparam logic [15:0] VOL_KEEP_MASK     = 16'h7FF8;
  // voltage limits and per-cell defaults, mV
  localparam logic [15:0] VOL_MIN_MV        = 16'h0400;
  localparam logic [15:0] VOL_MAX_MV        = 16'h4B00;
  localparam logic [15:0] VOL_DEF_1S        = 16'h1068;
  localparam logic [15:0] VOL_DEF_2S        = 16'h20D0;
  localparam logic [15:0] VOL_DEF_3S        = 16'h3138;
  localparam logic [15:0] VOL_DEF_4S        = 16'h41A0;
  // pre-charge and linear-mode clamps and thresholds
  localparam logic [15:0] PRECHG_CLAMP_MA   = 16'h0180;
  localparam logic [15:0] LIN_FAST_CLAMP_MA = 16'h07D0;
  localparam logic [15:0] ONE_CELL_PRE_MV   = 16'h0BB8;
  localparam logic [1:0]  STRAP_ONE_CELL    = 2'h0;
  // cycles before the synchronised strap is trusted
  localparam logic [2:0]  STRAP_SETTLE      = 3'h4;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_ADDR = 3'b001,
    SER_AACK = 3'b010,
    SER_RXB  = 3'b011,
    SER_RACK = 3'b100,
    SER_TXB  = 3'b101,
    SER_TACK = 3'b110
  } ser_state_t;
endpackage : charge_setpoint_pkg

// >>> tb/charge_setpoint_regs_sva.sv
// Purpose: port checks on the charge set-point bank
// Assumes: one clock mclk, synchronous active-high rst
// Notes:   clamp checks assume limit and flags update together
// ==================================================================
// checker
module charge_setpoint_regs_sva
  import charge_setpoint_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // clear controls
  input wire logic        reg_reset_cmd,
  input wire logic        watchdog_event,
  // set points and charge control
  input wire logic [15:0] charge_current_setpoint,
  input wire logic [15:0] charge_voltage_setpoint,
  input wire logic [15:0] current_limit_ma,
  input wire logic        charge_enable,
  input wire logic        precharge,
  input wire logic        battery_switch,
  input wire logic        regulate_at_vsys_min
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // clear request, then current gone, then enable drops
  sequence s_clear;
    watchdog_event || reg_reset_cmd;
  endsequence
  sequence s_cleared;
    (charge_current_setpoint == 16'h0000) ##1 !charge_enable;
  endsequence
  property p_cur_rsvd;
    charge_current_setpoint[15:13] == 3'h0
      && charge_current_setpoint[5:0] == 6'h00;
  endproperty
  a_cur_rsvd: assert property (p_cur_rsvd)
    else $error("reserved current bits set");
  property p_vol_fields;
    !charge_voltage_setpoint[15] && charge_voltage_setpoint[2:0] == 3'h0;
  endproperty
  a_vol_fields: assert property (p_vol_fields)
    else $error("reserved voltage bits set");
  property p_vol_range;
    charge_voltage_setpoint >= VOL_MIN_MV
      && charge_voltage_setpoint <= VOL_MAX_MV;
  endproperty
  a_vol_range: assert property (p_vol_range)
    else $error("voltage out of range");
  property p_clear;
    s_clear |=> s_cleared;
  endproperty
  a_clear: assert property (p_clear)
    else $error("current not cleared");
  property p_rst_zero;
    $fell(rst) |-> charge_current_setpoint == 16'h0000 && !charge_enable;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("current not zero after reset");
  property p_enable;
    charge_enable |-> charge_current_setpoint != 16'h0000
      || $past(charge_current_setpoint) != 16'h0000;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enabled with zero current");
  property p_pre_clamp;
    precharge && battery_switch |-> current_limit_ma <= PRECHG_CLAMP_MA;
  endproperty
  a_pre_clamp: assert property (p_pre_clamp)
    else $error("pre-charge limit above clamp");
  property p_lin_clamp;
    battery_switch |-> current_limit_ma <= LIN_FAST_CLAMP_MA;
  endproperty
  a_lin_clamp: assert property (p_lin_clamp)
    else $error("linear limit above clamp");
  property p_vsys_reg;
    $rose(battery_switch) |-> regulate_at_vsys_min;
  endproperty
  a_vsys_reg: assert property (p_vsys_reg)
    else $error("linear mode without vsys regulation");
endmodule : charge_setpoint_regs_sva

// >>> tb/ser_host.sv
// Purpose: host master on the two-wire serial pins
// Assumes: data line pulled up, device never stretches the clock
// Notes:   phases of ten mclk keep clear of the eight-cycle minimum
// ==================================================================
// host model
module ser_host
  import charge_setpoint_pkg::*;
(
  // clock
  input  wire logic mclk,
  // serial pins
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle at time zero
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // data moves three cycles after the fall, so no false start or stop
  task automatic dly(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : dly
  task automatic bit_x(input logic b, output logic r);
    dly(3);
    sda_pull = !b;
    dly(7);
    scl = 1'b1;
    dly(10);
    r   = sda;
    scl = 1'b0;
  endtask : bit_x
  // start and repeated start
  task automatic start();
    dly(3);
    sda_pull = 1'b0;
    dly(7);
    scl = 1'b1;
    dly(10);
    sda_pull = 1'b1;
    dly(10);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    dly(3);
    sda_pull = 1'b1;
    dly(7);
    scl = 1'b1;
    dly(10);
    sda_pull = 1'b0;
    dly(10);
  endtask : stop
  // eight bits out or in, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ak, nak);
  endtask : xfer
  // word write, low byte first, both bytes in one transaction
  task automatic wr16(input logic [6:0] a, input logic [7:0] o,
                      input logic [15:0] d, output logic nak);
    logic [7:0] q;
    logic       n;
    start();
    xfer({a, 1'b0}, 1'b1, q, nak);
    xfer(o, 1'b1, q, n);
    xfer(d[7:0], 1'b1, q, n);
    xfer(d[15:8], 1'b1, q, n);
    stop();
  endtask : wr16
  task automatic rd16(input logic [7:0] o, output logic [15:0] d);
    logic [7:0] q;
    logic       n;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, n);
    xfer(o, 1'b1, q, n);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, n);
    xfer(8'hFF, 1'b0, d[7:0], n);
    xfer(8'hFF, 1'b1, d[15:8], n);
    stop();
  endtask : rd16
endmodule : ser_host

// >>> tb/test_charge_current_voltage_regs.sv
// Purpose: self-checking bench for the charge set-point bank
// Assumes: host model on the serial pins, data line pulled up
// Notes:   outputs are checked after the stop, past every commit
// ==================================================================
// bench top
module test_charge_current_voltage_regs
  import charge_setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, scl_in, h_pull, sda_out, sda_oe, nak;
  logic input_power_good, input_present_flag, battery_present;
  logic sense_5mohm, linear_precharge_enable;
  logic reg_reset_cmd, watchdog_event;
  logic charge_enable, precharge, battery_switch, regulate_at_vsys_min;
  logic [1:0]  cell_count_strap;
  logic [15:0] vbat_mv, vsys_min_mv, charge_current_setpoint, rd;
  logic [15:0] charge_voltage_setpoint, current_limit_ma;
  int          err_count = 0;
  int          samples_checked = 0;
  wire         sda_w = !(sda_oe || h_pull);
  // {voltage word, write, current, voltage}
  localparam logic [51:0] ROWS [13] = '{
    52'h0_1FC0_1FC0_20D0, 52'h0_107F_1040_20D0, 52'h0_2040_1040_20D0,
    52'h0_8000_1040_20D0, 52'h1_0400_1040_0400, 52'h1_4B00_1040_4B00,
    52'h1_03F8_1040_4B00, 52'h1_4B08_1040_4B00, 52'h1_3007_1040_3000,
    52'h1_8400_1040_3000, 52'h1_0000_0000_3000, 52'h0_0040_0040_3000,
    52'h0_1000_1000_3000};
  localparam logic [15:0] DEFS [4] = '{VOL_DEF_1S, VOL_DEF_2S,
                                        VOL_DEF_3S, VOL_DEF_4S};
  // 10 MHz clock
  always #50 mclk = ~mclk;
  ser_host host (.mclk, .sda(sda_w), .scl(scl_in), .sda_pull(h_pull));
  charge_setpoint_regs uut (.mclk, .rst, .scl_in, .sda_in(sda_w),
    .sda_out, .sda_oe, .input_power_good, .input_present_flag,
    .battery_present, .cell_count_strap, .sense_5mohm,
    .linear_precharge_enable, .reg_reset_cmd, .watchdog_event, .vbat_mv,
    .vsys_min_mv, .charge_current_setpoint, .charge_voltage_setpoint,
    .current_limit_ma, .charge_enable, .precharge, .battery_switch,
    .regulate_at_vsys_min);
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // long reset lets the pin filters fill before release
  task automatic do_rst();
    rst = 1'b1;
    cyc(12);
    rst = 1'b0;
    cyc(10);
  endtask : do_rst
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // hang guard
  initial begin
    cyc(60000);
    err_count++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run();
  end
  // main sequence
  initial begin
    {input_power_good, input_present_flag, battery_present} = 3'h7;
    {sense_5mohm, reg_reset_cmd, watchdog_event} = 3'h0;
    linear_precharge_enable = 1'b1;
    cell_count_strap = 2'h1;
    vbat_mv = 16'h3A98;
    vsys_min_mv = 16'h2328;
    do_rst();
    for (int i = 0; i < 13; i++) begin
      host.wr16(DEV_ADDR, ROWS[i][48] ? VOL_LO_OFS : CUR_LO_OFS,
                ROWS[i][47:32], nak);
      chk(charge_current_setpoint, ROWS[i][31:16]);
      chk(charge_voltage_setpoint, ROWS[i][15:0]);
      chk(current_limit_ma, ROWS[i][31:16]);
      chk(16'(charge_enable), 16'(ROWS[i][31:16] != 0));
    end
    host.rd16(CUR_LO_OFS, rd);
    chk(rd, 16'h1000);
    host.rd16(VOL_LO_OFS, rd);
    chk(rd, 16'h3000);
    host.rd16(8'h10, rd);
    chk(rd, 16'h0000);
    // foreign address is refused and changes nothing
    host.wr16(DEV_ADDR ^ 7'h01, CUR_LO_OFS, 16'h0040, nak);
    chk(16'(nak), 16'h0001);
    chk(charge_current_setpoint, 16'h1000);
    // two-cell pre-charge, then linear mode off
    vbat_mv = 16'h1F40;
    cyc(4);
    chk(16'({precharge, battery_switch, regulate_at_vsys_min}), 16'h0007);
    chk(current_limit_ma, PRECHG_CLAMP_MA);
    linear_precharge_enable = 1'b0;
    cyc(4);
    chk(16'({precharge, battery_switch}), 16'h0002);
    chk(current_limit_ma, 16'h1000);
    vbat_mv = 16'h3A98;
    sense_5mohm = 1'b1;
    cyc(8);
    chk(current_limit_ma, 16'h2000);
    sense_5mohm = 1'b0;
    // each clearing event after a fresh current write
    for (int e = 0; e < 4; e++) begin
      host.wr16(DEV_ADDR, CUR_LO_OFS, 16'h0040, nak);
      case (e)
        0: watchdog_event = 1'b1;
        1: reg_reset_cmd = 1'b1;
        2: input_present_flag = 1'b0;
        default: battery_present = 1'b0;
      endcase
      cyc(1);
      {watchdog_event, reg_reset_cmd} = 2'h0;
      cyc(8);
      chk(charge_current_setpoint, 16'h0000);
      {input_present_flag, battery_present} = 2'h3;
      cyc(8);
    end
    chk(charge_voltage_setpoint, VOL_DEF_2S);
    host.wr16(DEV_ADDR, CUR_LO_OFS, 16'h0040, nak);
    input_power_good = 1'b0;
    cyc(8);
    chk(16'(charge_enable), 16'h0000);
    input_power_good = 1'b1;
    for (int s = 3; s >= 0; s--) begin
      cell_count_strap = 2'(s);
      do_rst();
      chk(charge_current_setpoint, CUR_RESET);
      chk(charge_voltage_setpoint, DEFS[s]);
    end
    // one cell: voltage written before current
    host.wr16(DEV_ADDR, VOL_LO_OFS, 16'h1000, nak);
    host.wr16(DEV_ADDR, CUR_LO_OFS, 16'h1000, nak);
    linear_precharge_enable = 1'b1;
    vsys_min_mv = 16'h0E10;
    vbat_mv = 16'h0B54;
    cyc(4);
    chk(16'({precharge, battery_switch}), 16'h0003);
    chk(current_limit_ma, PRECHG_CLAMP_MA);
    vbat_mv = ONE_CELL_PRE_MV;
    cyc(4);
    chk(16'({precharge, battery_switch}), 16'h0001);
    chk(current_limit_ma, LIN_FAST_CLAMP_MA);
    vbat_mv = 16'h0E74;
    cyc(4);
    chk(16'(battery_switch), 16'h0000);
    chk(current_limit_ma, 16'h1000);
    complete_run();
  end
endmodule : test_charge_current_voltage_regs
// checker beside the device ports
bind charge_setpoint_regs charge_setpoint_regs_sva chk (.mclk, .rst,
  .reg_reset_cmd, .watchdog_event, .charge_current_setpoint,
  .charge_voltage_setpoint, .current_limit_ma, .charge_enable,
  .precharge, .battery_switch, .regulate_at_vsys_min);
